// *** verilog/ees_pkg.sv ***
// Package of constants for the serial EEPROM slave front end
package ees_pkg;
  localparam logic [3:0] EES_TYPE_CODE    = 4'hA;
  localparam int         EES_ADDR_W       = 8;
  localparam int         EES_MEM_DEPTH    = 256;
  localparam logic [7:0] EES_PROT_BASE    = 8'h80;
  localparam int         EES_PAGE_SMALL   = 8;
  localparam int         EES_PAGE_LARGE   = 16;
  localparam int         EES_CLK_MHZ      = 200;
  localparam int         EES_TWC_MS       = 5;
  localparam int         EES_TWC_CYC      = EES_TWC_MS * 1000 * EES_CLK_MHZ;
  localparam int         EES_BIT_ACK      = 8;
  localparam logic [7:0] EES_MEM_RESET    = 8'hFF;
  typedef enum logic [2:0] {
    EES_IDLE, EES_CTRL, EES_WADDR, EES_WDATA, EES_READ, EES_IGNORE
  } ees_phase_t;
endpackage

// *** verilog/ees_slave.sv ***
// Two-wire serial EEPROM slave: conditions, addressing, page write, array
//
// Behaviour
// (RULE_01) Data falling while clock high is a Start.
// (RULE_02) Data rising while clock high is a Stop.
// (RULE_03) Data changes only while clock low; one clock pulse per bit.
// (RULE_04) Master starts only on idle bus, both lines high.
// (RULE_05) Device acknowledges each received byte on the ninth pulse.
// (RULE_06) No acknowledge at all while the internal write cycle runs.
// (RULE_07) Acknowledge holds data low through the whole ninth high phase.
// (RULE_08) Master not acknowledging read data makes device release the line.
// (RULE_09) Control byte acknowledged only when its top nibble is type code.
// (RULE_10) Cascadable variant compares three select bits with pins.
// (RULE_11) Lowest control bit one reads, zero writes.
// (RULE_12) Six-pin package master sends zero in top select bit.
// (RULE_13) Write control byte acked, then word address byte expected.
// (RULE_14) Word address loads pointer and is acked; then data is acked.
// (RULE_15) Stop after write data starts the timed internal write.
// (RULE_16) Page buffer of eight or sixteen bytes holds data until Stop.
// (RULE_17) Only the low page bits of the pointer increment per byte.
// (RULE_18) Excess bytes wrap within page, keeping the last page of bytes.
// (RULE_19) Page boundary crossing wraps to start of current page.
// (RULE_20) Upper half of array is never written; reads unaffected.
// (RULE_21) Lower half of array is written and read normally.
// (RULE_22) During write cycle control bytes are not acknowledged.
// (RULE_23) Pointer holds last accessed address plus one; here only write data bytes advance it, within the page.
// (RULE_24) Write time is a parameter; array updates only at its end.
`timescale 1ns/1ps
module ees_slave
  import ees_pkg::*;
#(
  parameter int         PAGE_BYTES  = EES_PAGE_LARGE,
  parameter bit         CASCADABLE  = 1'b1,
  parameter int         TWC_CYCLES  = EES_TWC_CYC
) (
  input  wire logic     ref_clk,
  input  wire logic     rst,
  input  wire logic     clk_en,
  input  wire logic     scl_clk,
  input  wire logic     sda_i,
  output logic          sda_o,
  output logic          sda_oe,
  input  wire logic     chip_select_pin_0,
  input  wire logic     chip_select_pin_1,
  input  wire logic     chip_select_pin_2,
  output logic          write_busy
);
  localparam int PG_W = $clog2(PAGE_BYTES);
  localparam int CNT_W = $clog2(TWC_CYCLES + 1);

  // ==========================================================
  // Link side: Start and Stop detection
  // ==========================================================
  // Conditions are sampled in the system domain from synchronised copies,
  // since the link clock is frozen whenever the data line moves alone.
  logic [1:0] scl_sync_q;
  logic [1:0] sda_sync_q;
  logic       scl_s_q;
  logic       sda_s_q;
  logic       start_ev;
  logic       stop_ev;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
      scl_s_q    <= 1'b1;
      sda_s_q    <= 1'b1;
    end else if (clk_en) begin
      scl_sync_q <= {scl_sync_q[0], scl_clk};
      sda_sync_q <= {sda_sync_q[0], sda_i};
      scl_s_q    <= scl_sync_q[1];
      sda_s_q    <= sda_sync_q[1];
    end
  end

  assign start_ev = clk_en && scl_sync_q[1] && scl_s_q && sda_s_q
                    && !sda_sync_q[1]; // RULE_01
  assign stop_ev  = clk_en && scl_sync_q[1] && scl_s_q && !sda_s_q
                    && sda_sync_q[1]; // RULE_02

  // Serial clock edges as seen through the synchronisers
  logic scl_rise;
  logic scl_fall;

  assign scl_rise = clk_en && scl_sync_q[1] && !scl_s_q;
  assign scl_fall = clk_en && !scl_sync_q[1] && scl_s_q;

  // ==========================================================
  // Link side: bit capture on the serial clock
  // ==========================================================
  // The data line is sampled at the rising edge by the serial clock itself.
  // The system side reads this flop only after the synchronised rising
  // edge, two flops later, when it has long settled; it then holds for
  // the rest of the bit, so no word ever crosses while it moves.
  logic link_bit_q;

  always_ff @(posedge scl_clk) begin
    link_bit_q <= sda_i; // RULE_03
  end

  // ==========================================================
  // Byte engine in the system domain
  // ==========================================================
  // The serial clock stops around Start and Stop, so the engine cannot
  // run on it alone; it runs on the system clock, which also lets the
  // byte engine share the one synchronous reset.
  logic [3:0]            bit_cnt_q;
  logic [7:0]            shift_q;
  ees_phase_t            phase_q;
  logic                  ack_pend_q;
  logic                  ack_q;
  logic [7:0]            ptr_q;
  logic [7:0]            buf_q [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] bvalid_q;
  logic [7:0]            rx_byte;
  logic [2:0]            cs_pins;
  logic                  byte_done;
  logic                  ack_slot;
  logic                  commit;

  // Control byte match on type code and, if cascadable, on the straps
  function automatic logic ees_match(input logic [7:0] b,
                                     input logic [2:0] pins);
    logic hit;
    hit = b[7:4] == EES_TYPE_CODE; // RULE_09
    if (CASCADABLE) begin
      hit = hit && b[3:1] == pins; // RULE_10
    end
    return hit;
  endfunction

  // Pins are straps, steady while the link runs
  assign cs_pins   = {chip_select_pin_2, chip_select_pin_1,
                      chip_select_pin_0};
  assign rx_byte   = {shift_q[6:0], link_bit_q};
  assign byte_done = scl_rise && bit_cnt_q == 4'h7;
  assign ack_slot  = scl_rise && bit_cnt_q == 4'(EES_BIT_ACK);

  // Bits are counted on synchronised rising edges of the serial clock
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      bit_cnt_q <= 4'h0;
      shift_q   <= 8'h00;
    end else if (start_ev) begin
      bit_cnt_q <= 4'h0; // RULE_01
    end else if (ack_slot) begin
      bit_cnt_q <= 4'h0; // RULE_05
    end else if (scl_rise) begin
      bit_cnt_q <= bit_cnt_q + 4'h1; // RULE_03
      shift_q   <= rx_byte;
    end
  end

  // Transfer phase and whether the coming ninth pulse is ours
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      phase_q    <= EES_IDLE;
      ack_pend_q <= 1'b0;
    end else if (start_ev) begin
      phase_q    <= EES_CTRL; // RULE_01
      ack_pend_q <= 1'b0;
    end else if (stop_ev) begin
      phase_q    <= EES_IDLE; // RULE_02
      ack_pend_q <= 1'b0;
    end else if (byte_done) begin
      unique case (phase_q)
        EES_CTRL: begin
          // A busy device stays silent, which is what pollers wait on
          if (ees_match(rx_byte, cs_pins) && !write_busy) begin // RULE_22
            phase_q    <= rx_byte[0] ? EES_READ : EES_WADDR; // RULE_11
            ack_pend_q <= 1'b1; // RULE_13
          end else begin
            phase_q    <= EES_IGNORE;
            ack_pend_q <= 1'b0;
          end
        end
        EES_WADDR: begin
          phase_q    <= EES_WDATA; // RULE_14
          ack_pend_q <= 1'b1;
        end
        EES_WDATA: begin
          ack_pend_q <= 1'b1; // RULE_14
        end
        EES_READ, EES_IDLE, EES_IGNORE: begin
          // Read bytes are acknowledged by the master; the line stays free
          ack_pend_q <= 1'b0; // RULE_08
        end
        default: begin
          phase_q    <= EES_IDLE;
          ack_pend_q <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // Address pointer and page buffer
  // ==========================================================
  // Pointer keeps last written address plus one, wrapping within the page (RULE_23)
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ptr_q <= 8'h00;
    end else if (byte_done && phase_q == EES_WADDR) begin
      ptr_q <= rx_byte; // RULE_14
    end else if (byte_done && phase_q == EES_WDATA) begin
      // Only the page index moves, so the page never changes
      ptr_q[PG_W-1:0] <= ptr_q[PG_W-1:0] + 1'b1; // RULE_17 RULE_19
    end
  end

  // One slot per page byte; a later byte to the same slot replaces it
  for (genvar g = 0; g < PAGE_BYTES; g++) begin : g_page
    always_ff @(posedge ref_clk) begin
      if (rst) begin
        bvalid_q[g] <= 1'b0;
      end else if (commit || (byte_done && phase_q == EES_WADDR)) begin
        bvalid_q[g] <= 1'b0;
      end else if (byte_done && phase_q == EES_WDATA
                   && ptr_q[PG_W-1:0] == PG_W'(g)) begin
        bvalid_q[g] <= 1'b1; // RULE_18
      end
    end

    always_ff @(posedge ref_clk) begin
      if (byte_done && phase_q == EES_WDATA
          && ptr_q[PG_W-1:0] == PG_W'(g)) begin
        buf_q[g] <= rx_byte; // RULE_16
      end
    end
  end

  // ==========================================================
  // Acknowledge drive
  // ==========================================================
  // Set and cleared on synchronised falling edges, a few system cycles after
  // the master's fall, so the line is settled across the high phase; Start and Stop also clear it.
  always_ff @(posedge ref_clk) begin
    if (rst || start_ev || stop_ev) begin
      ack_q <= 1'b0;
    end else if (scl_fall) begin
      ack_q <= bit_cnt_q == 4'(EES_BIT_ACK) && ack_pend_q // RULE_07
               && !write_busy; // RULE_06
    end
  end

  // Read data is outside this block; only the low level is ever driven
  assign sda_o  = 1'b0;
  assign sda_oe = ack_q; // RULE_05

  // ==========================================================
  // Timed write cycle and array
  // ==========================================================
  logic [7:0]       mem_q [EES_MEM_DEPTH];
  logic [CNT_W-1:0] twc_cnt_q;
  logic             go_write;

  // A Stop with no data bytes, as in polling, starts nothing
  assign go_write = stop_ev && phase_q == EES_WDATA && |bvalid_q
                    && !write_busy;
  assign commit   = clk_en && write_busy && twc_cnt_q == '0;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      write_busy <= 1'b0;
      twc_cnt_q  <= '0;
    end else if (go_write) begin
      write_busy <= 1'b1; // RULE_15
      twc_cnt_q  <= CNT_W'(TWC_CYCLES - 1); // RULE_24
    end else if (clk_en && write_busy) begin
      if (twc_cnt_q != '0) begin
        twc_cnt_q <= twc_cnt_q - 1'b1;
      end else begin
        write_busy <= 1'b0;
      end
    end
  end

  // Array updates only at the end of the cycle; the buffer and pointer
  // cannot move meanwhile because every control byte is refused
  always_ff @(posedge ref_clk) begin
    if (commit) begin
      for (int i = 0; i < PAGE_BYTES; i++) begin
        if (bvalid_q[i] && ptr_q < EES_PROT_BASE) begin // RULE_20 RULE_21
          mem_q[{ptr_q[7:PG_W], PG_W'(i)}] <= buf_q[i]; // RULE_24
        end
      end
    end
  end

  // ==========================================================
  // Checks
  // ==========================================================
  default clocking cb_ref @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  no_ack_busy_a: assert property ( // RULE_06
    write_busy |-> !sda_oe)
    else $error("acknowledge driven during write cycle");

  busy_len_a: assert property ( // RULE_24
    $rose(write_busy) |-> write_busy [*8])
    else $error("write cycle ended too early");

  stop_commit_a: assert property ( // RULE_15
    go_write |=> write_busy)
    else $error("stop after data did not start write");

  start_det_a: assert property ( // RULE_01
    start_ev |=> phase_q == EES_CTRL && bit_cnt_q == 4'h0)
    else $error("start did not restart the byte engine");

  stop_det_a: assert property ( // RULE_02
    stop_ev |=> phase_q == EES_IDLE)
    else $error("stop did not end the transfer");

  ack_slot_a: assert property ( // RULE_05
    $rose(sda_oe) |-> bit_cnt_q == 4'(EES_BIT_ACK))
    else $error("line driven outside acknowledge slot");

  ack_steady_a: assert property ( // RULE_07
    scl_sync_q[1] && scl_s_q |-> $stable(sda_oe))
    else $error("acknowledge moved while clock high");

  page_wrap_a: assert property ( // RULE_19
    byte_done && phase_q == EES_WDATA
    |=> ptr_q[7:PG_W] == $past(ptr_q[7:PG_W]))
    else $error("page write left current page");

  ptr_step_a: assert property ( // RULE_17
    byte_done && phase_q == EES_WDATA
    |=> ptr_q[PG_W-1:0] == PG_W'($past(ptr_q[PG_W-1:0]) + 1))
    else $error("page index did not advance by one");

  ignore_hold_a: assert property ( // RULE_09
    phase_q == EES_IGNORE && !start_ev && !stop_ev
    |=> phase_q == EES_IGNORE)
    else $error("ignored transfer became active");

  busy_mute_a: assert property ( // RULE_22
    byte_done && phase_q == EES_CTRL && write_busy
    |=> phase_q == EES_IGNORE)
    else $error("control byte taken during write cycle");

endmodule

// *** verification/ees_master_model.sv ***
// Behavioural two-wire bus master for the serial EEPROM slave
`timescale 1ns/1ps
module ees_master_model (
  output logic      scl,
  output logic      sda_m,
  input  wire logic sda_bus
);
  localparam time Q = 40;
  initial begin
    scl   = 1'b1;
    sda_m = 1'b1;
  end
  // ==========================================================
  // Bus conditions
  // Odd offset keeps serial edges away from system clock edges
  task automatic bus_start();
    #1.3;
    sda_m <= 1'b1;
    #(2*Q);
    sda_m <= 1'b0;
    #(2*Q);
    scl <= 1'b0;
    #Q;
  endtask
  task automatic bus_stop();
    sda_m <= 1'b0;
    #Q;
    scl <= 1'b1;
    #(2*Q);
    sda_m <= 1'b1;
    #(2*Q);
  endtask
  // ==========================================================
  // Bits and bytes; low_all means line low at both the start and the end of the high phase
  task automatic bit_out(input logic b, output logic low_all);
    sda_m <= b;
    #Q;
    scl <= 1'b1;
    #1;
    low_all = ~sda_bus;
    #(2*Q-2);
    low_all = low_all & ~sda_bus;
    #1;
    scl <= 1'b0;
    #Q;
  endtask
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic dummy;
    for (int i = 7; i >= 0; i--) bit_out(b[i], dummy);
    bit_out(1'b1, ack);
  endtask
endmodule

// *** verification/ees_slave_tb.sv ***
// Self-checking testbench for the serial EEPROM slave front end
`timescale 1ns/1ps
module ees_slave_tb;
  import ees_pkg::*;
  localparam int TWC = 2000;
  logic       ref_clk    = 1'b0;
  logic       rst        = 1'b1;
  logic [2:0] cs         = 3'h5;
  logic       scl;
  logic       sda_m;
  logic       sda_o;
  logic       sda_oe;
  logic       write_busy;
  int         num_errors = 0;
  int         n_tests    = 0;
  int         busy_len   = 0;
  int         busy_last  = 0;
  // Open drain line with pull-up
  wire        sda_bus    = sda_m & ~(sda_oe & ~sda_o);
  always #2.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    if (write_busy === 1'b1) begin
      busy_len <= busy_len + 1;
    end else if (busy_len != 0) begin
      busy_last <= busy_len;
      busy_len  <= 0;
    end
  end
  ees_slave #(.PAGE_BYTES(EES_PAGE_LARGE), .CASCADABLE(1'b1),
              .TWC_CYCLES(TWC)) i_dut (
    .ref_clk(ref_clk), .rst(rst), .clk_en(1'b1), .scl_clk(scl),
    .sda_i(sda_bus), .sda_o(sda_o), .sda_oe(sda_oe),
    .chip_select_pin_0(cs[0]), .chip_select_pin_1(cs[1]),
    .chip_select_pin_2(cs[2]), .write_busy(write_busy));
  ees_master_model i_mst (.scl(scl), .sda_m(sda_m), .sda_bus(sda_bus));
  // ==========================================================
  // Shared helpers
  task automatic end_of_test();
    $display("errors %0d of %0d checks", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic check(input logic got, input logic exp, input string m);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  task automatic wait_busy(input logic lvl, input int lim);
    int n;
    n = 0;
    while (write_busy !== lvl) begin
      @(posedge ref_clk);
      #1;
      n++;
      if (n > lim) begin
        num_errors++;
        $display("wrong value at %0t: busy wait ran out", $time);
        end_of_test();
      end
    end
  endtask
  // Control byte, then address and n data bytes unless n is negative
  task automatic wr(input logic [7:0] ctl, input logic [7:0] adr,
                    input int n, input logic ea);
    logic a;
    i_mst.bus_start();
    i_mst.send_byte(ctl, a);
    check(a, ea, "control ack");
    if (n >= 0) begin
      i_mst.send_byte(adr, a);
      check(a, ea, "address ack");
      for (int i = 0; i < n; i++) begin
        i_mst.send_byte(adr ^ 8'(i), a);
        check(a, ea, "data ack");
      end
    end
    i_mst.bus_stop();
  endtask
  // ==========================================================
  // Scenarios
  task automatic sc_write_poll();
    wr({EES_TYPE_CODE, cs, 1'b0}, 8'h15, 1, 1'b1);
    wait_busy(1'b1, 20);
    check(i_dut.mem_q[8'h15] === 8'h15, 1'b0, "early write");
    wr({EES_TYPE_CODE, cs, 1'b0}, 8'h00, -1, 1'b0);
    check(write_busy, 1'b1, "busy dropped early");
    wait_busy(1'b0, TWC);
    @(posedge ref_clk);
    #1;
    check(busy_last == TWC, 1'b1, "write time");
    check(i_dut.mem_q[8'h15] === 8'h15, 1'b1, "byte write");
    wr({EES_TYPE_CODE, cs, 1'b0}, 8'h00, -1, 1'b1);
  endtask
  task automatic sc_type();
    for (int t = 0; t < 16; t++) begin
      wr({4'(t), cs, 1'b0}, 8'h00, -1, 4'(t) == EES_TYPE_CODE);
    end
  endtask
  task automatic sc_select();
    for (int p = 0; p < 2; p++) begin
      @(posedge ref_clk);
      cs <= p ? 3'h2 : 3'h5;
      for (int s = 0; s < 16; s++) begin
        wr({EES_TYPE_CODE, 4'(s)}, 8'h00, -1,
           3'(s >> 1) == (p ? 3'h2 : 3'h5));
      end
    end
  endtask
  task automatic sc_page();
    logic [7:0] a;
    logic [7:0] v;
    // Crosses the page end and overruns it by two bytes
    wr({EES_TYPE_CODE, cs, 1'b0}, 8'h7E, 18, 1'b1);
    wait_busy(1'b1, 20);
    wait_busy(1'b0, TWC + 10);
    @(posedge ref_clk);
    #1;
    // Byte i lands at the page slot 14 + i; the first two are replaced
    for (int k = 0; k < 16; k++) begin
      a = 8'h70 + 8'(k);
      v = 8'h7E ^ 8'(k + 2);
      check(i_dut.mem_q[a] === v, 1'b1, "page byte");
    end
    // Protected half still acknowledges its bytes
    wr({EES_TYPE_CODE, cs, 1'b0}, 8'hF8, 2, 1'b1);
    wait_busy(1'b1, 20);
    wait_busy(1'b0, TWC + 10);
    @(posedge ref_clk);
    #1;
    check(i_dut.mem_q[8'hF8] === 8'hF8, 1'b0, "protected write");
    wr({EES_TYPE_CODE, cs, 1'b0}, 8'h00, -1, 1'b1);
  endtask
  initial begin
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    sc_write_poll();
    sc_type();
    sc_select();
    sc_page();
    end_of_test();
  end
endmodule
